// >>> design/tsu_unit.sv
// What this block does
// (RQ1) System call raises the system-call exception.
// (RQ2) System call allowed in user mode.
// (RQ3) No enabled condition true: continue, no exception.
// (RQ4) Register trap compares first with second register.
// (RQ5) Immediate trap compares with sign-extended immediate.
// (RQ6) Mask bits independent; any true enabled fires.
// (RQ7) All mask bits set always traps.
// (RQ8) Mask bit 0: signed less-than.
// (RQ9) Mask bit 1: signed greater-than.
// (RQ10) Mask bit 2: equal.
// (RQ11) Mask bit 3: unsigned less-than.
// (RQ12) Mask bit 4: unsigned greater-than.
// (RQ13) Immediate index: sign-extend displacement, add base.
// (RQ14) Register index: base plus index register.
// (RQ15) Base selector zero means literal zero base.
// (RQ16) Update forms write address back to base.
// (RQ17) Memory order free; sync enforces strict order.
// (RQ18) Register-indirect only for string accesses.
// (RQ19) Five-bit mask, full 32-bit compares.
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`include "tsu_map.svh"
`default_nettype none
module tsu_unit (
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [31:0]      HRDATA,
    output logic             IRQ,
    input  wire logic        OP_VALID,
    output logic             OP_READY,
    input  wire logic [2:0]  OP_CODE,
    input  wire logic [4:0]  TRAP_CONDITION_MASK,
    input  wire logic [31:0] BASE_VALUE,
    input  wire logic [31:0] INDEX_VALUE,
    input  wire logic [15:0] SIGNED_IMMEDIATE,
    input  wire logic [4:0]  BASE_REG_SEL,
    input  wire logic        UPDATE_FORM,
    input  wire logic        STRING_OP,
    input  wire logic        USER_MODE,
    input  wire logic        MEM_PENDING,
    output logic             RES_VALID,
    output logic             SYSCALL_EXC,
    output logic             PROG_EXC,
    output logic             NEXT_SEQ,
    output logic             MODE_ERR,
    output logic             EA_VALID,
    output logic [31:0]      EA,
    output logic             WB_EN,
    output logic [4:0]       WB_SEL,
    output logic [31:0]      WB_DATA,
    output logic             FENCE_DONE
);
    tsu_pkg::tsu_state_t s_reg;
    tsu_pkg::tsu_state_t s_next;

    logic        take;
    logic [31:0] op_b;
    logic [31:0] base;
    logic [31:0] ea_sum;
    logic [4:0]  cond;
    logic        trap_hit;
    logic        is_trap;
    logic [2:0]  ev;
    logic        ap_take;
    logic [7:0]  ra;

    // (RQ17) Sync stalls until outstanding accesses drain.
    assign OP_READY = s_reg.ctrl_en && (s_reg.fsm == tsu_pkg::TSU_RUN);
    assign take     = OP_VALID && OP_READY;
    assign is_trap  = (OP_CODE == `TSU_OP_TRAP_REG) ||
                      (OP_CODE == `TSU_OP_TRAP_IMM);

    always_comb begin
        // (RQ4) Register form uses the index register value.
        op_b = INDEX_VALUE;
        // (RQ5) Immediate form sign-extends to full width.
        if (OP_CODE == `TSU_OP_TRAP_IMM) begin
            op_b = {{16{SIGNED_IMMEDIATE[15]}}, SIGNED_IMMEDIATE};
        end
        // (RQ13) Displacement widened by sign before the add.
        if (OP_CODE == `TSU_OP_EA_IMM) begin
            op_b = {{16{SIGNED_IMMEDIATE[15]}}, SIGNED_IMMEDIATE};
        end
        if (OP_CODE == `TSU_OP_EA_IND) begin
            op_b = 32'h0000_0000;
        end
    end

    // (RQ15) Selector zero yields a literal zero base.
    assign base = (BASE_REG_SEL == 5'h00) ? 32'h0000_0000 : BASE_VALUE;
    // (RQ14) Base plus index (or displacement) gives the address.
    assign ea_sum = base + op_b;

    always_comb begin
        // (RQ19) Full-width compares against a five-bit mask.
        // (RQ8) Signed less-than.
        cond[`TSU_TO_SLT] = $signed(BASE_VALUE) < $signed(op_b);
        // (RQ9) Signed greater-than.
        cond[`TSU_TO_SGT] = $signed(BASE_VALUE) > $signed(op_b);
        // (RQ10) Equality.
        cond[`TSU_TO_EQ]  = BASE_VALUE == op_b;
        // (RQ11) Unsigned less-than.
        cond[`TSU_TO_ULT] = BASE_VALUE < op_b;
        // (RQ12) Unsigned greater-than.
        cond[`TSU_TO_UGT] = BASE_VALUE > op_b;
    end

    // (RQ6) Any enabled true condition fires; one of SLT/SGT/EQ
    // is always true, so a full mask always traps.
    // (RQ7) Full mask therefore always traps.
    assign trap_hit = |(cond & TRAP_CONDITION_MASK);

    assign ap_take = HSEL && HREADY && (HTRANS == `TSU_HTRANS_NSEQ);
    assign ra      = HADDR[7:0];

    always_comb begin
        s_next             = s_reg;
        ev                 = 3'h0;
        s_next.res_valid   = 1'b0;
        s_next.syscall_exc = 1'b0;
        s_next.prog_exc    = 1'b0;
        s_next.next_seq    = 1'b0;
        s_next.mode_err    = 1'b0;
        s_next.ea_valid    = 1'b0;
        s_next.wb_en       = 1'b0;
        s_next.fence_done  = 1'b0;

        case (s_reg.fsm)
            tsu_pkg::TSU_RUN: begin
                if (take) begin
                    s_next.res_valid = 1'b1;
                    case (OP_CODE)
                        `TSU_OP_SYSCALL: begin
                            // (RQ1) Raise system-call exception.
                            // (RQ2) No privilege check on USER_MODE.
                            s_next.syscall_exc = 1'b1;
                            ev[`TSU_EV_SYSCALL] = 1'b1;
                        end
                        `TSU_OP_TRAP_REG, `TSU_OP_TRAP_IMM: begin
                            if (trap_hit) begin
                                s_next.prog_exc = 1'b1;
                                ev[`TSU_EV_TRAP] = 1'b1;
                                s_next.trap_cnt = s_reg.trap_cnt + 32'h1;
                            end else begin
                                // (RQ3) Fall through to next instruction.
                                s_next.next_seq = 1'b1;
                            end
                        end
                        `TSU_OP_EA_IMM, `TSU_OP_EA_IDX: begin
                            s_next.next_seq = 1'b1;
                            s_next.ea_valid = 1'b1;
                            s_next.ea       = ea_sum;
                            s_next.last_ea  = ea_sum;
                            // (RQ16) Update form writes address to base.
                            s_next.wb_en    = UPDATE_FORM;
                            s_next.wb_sel   = BASE_REG_SEL;
                        end
                        `TSU_OP_EA_IND: begin
                            // (RQ18) Only string accesses may use it.
                            if (STRING_OP) begin
                                s_next.next_seq = 1'b1;
                                s_next.ea_valid = 1'b1;
                                s_next.ea       = ea_sum;
                                s_next.last_ea  = ea_sum;
                            end else begin
                                s_next.mode_err = 1'b1;
                                ev[`TSU_EV_MODEERR] = 1'b1;
                            end
                        end
                        `TSU_OP_SYNC: begin
                            // (RQ17) Hold issue until memory drains.
                            if (MEM_PENDING) begin
                                s_next.res_valid = 1'b0;
                                s_next.fsm = tsu_pkg::TSU_FENCE;
                            end else begin
                                s_next.next_seq   = 1'b1;
                                s_next.fence_done = 1'b1;
                            end
                        end
                        default: begin
                            s_next.next_seq = 1'b1;
                        end
                    endcase
                end
            end
            tsu_pkg::TSU_FENCE: begin
                if (!MEM_PENDING) begin
                    s_next.fsm        = tsu_pkg::TSU_RUN;
                    s_next.res_valid  = 1'b1;
                    s_next.next_seq   = 1'b1;
                    s_next.fence_done = 1'b1;
                end
            end
            default: begin
                s_next.fsm = tsu_pkg::TSU_RUN;
            end
        endcase

        // Bus data phase: writes land now, reads were staged earlier.
        if (s_reg.ap_wr) begin
            case (s_reg.ap_addr)
                `TSU_OFF_CTRL: begin
                    s_next.ctrl_en = HWDATA[`TSU_CTRL_EN];
                end
                `TSU_OFF_IRQMASK: begin
                    s_next.irq_mask = HWDATA[`TSU_EV_W-1:0];
                end
                `TSU_OFF_TRAPCNT: begin
                    s_next.trap_cnt = HWDATA;
                end
                default: begin
                    s_next.ap_wr = 1'b0;
                end
            endcase
        end
        s_next.ap_wr = 1'b0;

        if (ap_take) begin
            s_next.ap_wr   = HWRITE;
            s_next.ap_addr = ra;
            s_next.rdata   = 32'h0000_0000;
            if (!HWRITE) begin
                case (ra)
                    `TSU_OFF_CTRL:    s_next.rdata = {31'h0, s_reg.ctrl_en};
                    `TSU_OFF_STATUS:  s_next.rdata = {29'h0, s_reg.status};
                    `TSU_OFF_IRQMASK: s_next.rdata = {29'h0, s_reg.irq_mask};
                    `TSU_OFF_TRAPCNT: s_next.rdata = s_reg.trap_cnt;
                    `TSU_OFF_LASTEA:  s_next.rdata = s_reg.last_ea;
                    default:          s_next.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Status clears on read; a same-cycle event still sets.
        if (ap_take && !HWRITE && (ra == `TSU_OFF_STATUS)) begin
            s_next.status = ev;
        end else begin
            s_next.status = s_reg.status | ev;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_reg          <= '0;
            s_reg.fsm      <= tsu_pkg::TSU_RUN;
            s_reg.ctrl_en  <= `TSU_CTRL_RST;
            s_reg.irq_mask <= `TSU_MASK_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign HREADYOUT   = 1'b1;
    assign HRESP       = 1'b0;
    assign HRDATA      = s_reg.rdata;
    assign IRQ         = |(s_reg.status & s_reg.irq_mask);
    assign RES_VALID   = s_reg.res_valid;
    assign SYSCALL_EXC = s_reg.syscall_exc;
    assign PROG_EXC    = s_reg.prog_exc;
    assign NEXT_SEQ    = s_reg.next_seq;
    assign MODE_ERR    = s_reg.mode_err;
    assign EA_VALID    = s_reg.ea_valid;
    assign EA          = s_reg.ea;
    assign WB_EN       = s_reg.wb_en;
    assign WB_SEL      = s_reg.wb_sel;
    assign WB_DATA     = s_reg.ea;
    assign FENCE_DONE  = s_reg.fence_done;
endmodule
`default_nettype wire

// >>> design/tsu_map.svh
`ifndef TSU_MAP_SVH
`define TSU_MAP_SVH
`define TSU_ADDR_W       8
`define TSU_OFF_CTRL     8'h00
`define TSU_OFF_STATUS   8'h04
`define TSU_OFF_IRQMASK  8'h08
`define TSU_OFF_TRAPCNT  8'h0c
`define TSU_OFF_LASTEA   8'h10
`define TSU_CTRL_EN      0
`define TSU_CTRL_RST     1'h1
`define TSU_EV_SYSCALL   0
`define TSU_EV_TRAP      1
`define TSU_EV_MODEERR   2
`define TSU_EV_W         3
`define TSU_MASK_RST     3'h0
`define TSU_OP_NOP       3'h0
`define TSU_OP_SYSCALL   3'h1
`define TSU_OP_TRAP_REG  3'h2
`define TSU_OP_TRAP_IMM  3'h3
`define TSU_OP_EA_IMM    3'h4
`define TSU_OP_EA_IDX    3'h5
`define TSU_OP_EA_IND    3'h6
`define TSU_OP_SYNC      3'h7
`define TSU_TO_SLT       0
`define TSU_TO_SGT       1
`define TSU_TO_EQ        2
`define TSU_TO_ULT       3
`define TSU_TO_UGT       4
`define TSU_HTRANS_NSEQ  2'h2
`endif

// >>> design/tsu_pkg.sv
`default_nettype none
package tsu_pkg;
    typedef enum logic [0:0] {
        TSU_RUN   = 1'b0,
        TSU_FENCE = 1'b1
    } tsu_fsm_t;

    typedef struct packed {
        tsu_fsm_t    fsm;
        logic        ctrl_en;
        logic [2:0]  irq_mask;
        logic [2:0]  status;
        logic [31:0] trap_cnt;
        logic [31:0] last_ea;
        logic        ap_wr;
        logic [7:0]  ap_addr;
        logic [31:0] rdata;
        logic        res_valid;
        logic        syscall_exc;
        logic        prog_exc;
        logic        next_seq;
        logic        mode_err;
        logic        ea_valid;
        logic [31:0] ea;
        logic        wb_en;
        logic [4:0]  wb_sel;
        logic        fence_done;
    } tsu_state_t;
endpackage
`default_nettype wire

// >>> testbench/tsu_unit_assertions.sv
`default_nettype none
module tsu_unit_assertions (
    input wire logic        CLOCK,
    input wire logic        SYS_RST,
    input wire logic        OP_VALID,
    input wire logic        OP_READY,
    input wire logic [2:0]  OP_CODE,
    input wire logic [4:0]  TRAP_CONDITION_MASK,
    input wire logic [31:0] BASE_VALUE,
    input wire logic [31:0] INDEX_VALUE,
    input wire logic [15:0] SIGNED_IMMEDIATE,
    input wire logic [4:0]  BASE_REG_SEL,
    input wire logic        UPDATE_FORM,
    input wire logic        STRING_OP,
    input wire logic        MEM_PENDING,
    input wire logic        RES_VALID,
    input wire logic        SYSCALL_EXC,
    input wire logic        PROG_EXC,
    input wire logic        NEXT_SEQ,
    input wire logic        MODE_ERR,
    input wire logic        EA_VALID,
    input wire logic [31:0] EA,
    input wire logic        WB_EN,
    input wire logic [4:0]  WB_SEL,
    input wire logic [31:0] WB_DATA,
    input wire logic        FENCE_DONE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    logic        take;
    logic        hit;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] base0;
    logic [31:0] signed_immediate;
    logic [4:0]  m;
    assign take = OP_VALID && OP_READY;
    assign base0 = (BASE_REG_SEL == 5'h0) ? 32'h0 : BASE_VALUE;
    assign signed_immediate = {{16{SIGNED_IMMEDIATE[15]}}, SIGNED_IMMEDIATE};
    assign m = TRAP_CONDITION_MASK;
    assign a = BASE_VALUE;
    assign b = (OP_CODE == 3'h2) ? INDEX_VALUE : signed_immediate;
    assign hit = (m[0] && $signed(a) < $signed(b))
        || (m[1] && $signed(a) > $signed(b))
        || (m[2] && a == b) || (m[3] && a < b) || (m[4] && a > b);
    sequence s_trap_take;
        take && (OP_CODE == 3'h2 || OP_CODE == 3'h3);
    endsequence
    sequence s_sync_take;
        take && OP_CODE == 3'h7;
    endsequence
    a_syscall_raise: assert property (
        take && OP_CODE == 3'h1 |=> SYSCALL_EXC && RES_VALID && !PROG_EXC)
        else $error("system call did not raise its exception");
    a_trap_cond_hit: assert property (
        s_trap_take |=> PROG_EXC == $past(hit) && RES_VALID)
        else $error("trap outcome differs from compare");
    a_trap_miss_seq: assert property (
        s_trap_take ##0 !hit |=> NEXT_SEQ && !PROG_EXC)
        else $error("untaken trap did not continue");
    a_all_mask_trap: assert property (
        s_trap_take ##0 m == 5'h1f |=> PROG_EXC)
        else $error("full mask did not trap");
    a_ea_imm_sum: assert property (
        take && OP_CODE == 3'h4 |=> EA_VALID
        && EA == $past(base0) + $past(signed_immediate))
        else $error("immediate index address wrong");
    a_ea_idx_sum: assert property (
        take && OP_CODE == 3'h5 |=> EA_VALID
        && EA == $past(base0) + $past(INDEX_VALUE))
        else $error("register index address wrong");
    a_update_wb: assert property (
        take && OP_CODE[2:1] == 2'b10 && UPDATE_FORM |=> WB_EN
        && WB_DATA == EA && WB_SEL == $past(BASE_REG_SEL))
        else $error("update form write-back wrong");
    a_indirect_str: assert property (
        take && OP_CODE == 3'h6 |=> MODE_ERR == !$past(STRING_OP)
        && (MODE_ERR || EA == $past(base0)))
        else $error("indirect mode handling wrong");
    a_sync_hold: assert property (
        s_sync_take ##0 MEM_PENDING |=> !OP_READY && !FENCE_DONE)
        else $error("barrier did not hold while memory busy");
    a_sync_quick: assert property (
        s_sync_take ##0 !MEM_PENDING |=> FENCE_DONE && RES_VALID)
        else $error("barrier with idle memory did not finish");
endmodule

bind tsu_unit tsu_unit_assertions tsu_unit_assertions_i (.CLOCK, .SYS_RST,
    .OP_VALID, .OP_READY, .OP_CODE, .TRAP_CONDITION_MASK, .BASE_VALUE,
    .INDEX_VALUE, .SIGNED_IMMEDIATE, .BASE_REG_SEL, .UPDATE_FORM, .STRING_OP,
    .MEM_PENDING, .RES_VALID, .SYSCALL_EXC, .PROG_EXC, .NEXT_SEQ, .MODE_ERR,
    .EA_VALID, .EA, .WB_EN, .WB_SEL, .WB_DATA, .FENCE_DONE);
`default_nettype wire

// >>> testbench/tsu_unit_tb.sv
`default_nettype none
module tsu_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLOCK, SYS_RST, HSEL, HWRITE, HREADYOUT, HRESP, IRQ;
    logic        OP_VALID, OP_READY, UPDATE_FORM, STRING_OP, USER_MODE;
    logic        MEM_PENDING, RES_VALID, SYSCALL_EXC, PROG_EXC, NEXT_SEQ;
    logic        MODE_ERR, EA_VALID, WB_EN, FENCE_DONE, upd, str;
    logic [1:0]  HTRANS;
    logic [2:0]  OP_CODE;
    logic [4:0]  TRAP_CONDITION_MASK, BASE_REG_SEL, WB_SEL;
    logic [15:0] SIGNED_IMMEDIATE;
    logic [31:0] HADDR, HWDATA, HRDATA, BASE_VALUE, INDEX_VALUE, EA, WB_DATA;
    logic [31:0] rd;
    int          failures = 0;
    int          n_compared = 0;
    int          cyc = 0;

    tsu_unit tsu_unit_i (.CLOCK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
        .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HREADYOUT, .HRESP,
        .HRDATA, .IRQ, .OP_VALID, .OP_READY, .OP_CODE, .TRAP_CONDITION_MASK,
        .BASE_VALUE, .INDEX_VALUE, .SIGNED_IMMEDIATE, .BASE_REG_SEL,
        .UPDATE_FORM, .STRING_OP, .USER_MODE, .MEM_PENDING, .RES_VALID,
        .SYSCALL_EXC, .PROG_EXC, .NEXT_SEQ, .MODE_ERR, .EA_VALID, .EA,
        .WB_EN, .WB_SEL, .WB_DATA, .FENCE_DONE);

    always #12.5 CLOCK = ~CLOCK;

    task automatic chk(input string n, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic final_report;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            final_report;
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HTRANS <= 2'h2;
        HWRITE <= w;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask

    task automatic op(input logic [2:0] c, input logic [4:0] m,
                      input logic [31:0] b, x, input logic [15:0] i,
                      input logic [4:0] s);
        @(posedge CLOCK);
        OP_VALID <= 1'b1;
        OP_CODE <= c;
        TRAP_CONDITION_MASK <= m;
        BASE_VALUE <= b;
        INDEX_VALUE <= x;
        SIGNED_IMMEDIATE <= i;
        BASE_REG_SEL <= s;
        UPDATE_FORM <= upd;
        STRING_OP <= str;
        do @(posedge CLOCK); while (OP_READY !== 1'b1);
        OP_VALID <= 1'b0;
        #1;
    endtask

    task automatic t_regs;
        chk("op_ready", OP_READY, 1);
        chk("hreadyout", HREADYOUT, 1);
        chk("hresp", HRESP, 0);
        bus(0, 8'h00, 0);
        chk("ctrl", rd, 32'h1);
        bus(0, 8'h08, 0);
        chk("irqmask", rd, 0);
        bus(1, 8'h40, 32'h5a);
        bus(0, 8'h40, 0);
        chk("unmapped", rd, 0);
        bus(1, 8'h0c, 32'h5);
        bus(1, 8'h00, 0);
        #1;
        chk("op_ready_off", OP_READY, 0);
        bus(1, 8'h00, 32'h1);
    endtask

    // Syscall issued in user mode must still raise its exception.
    task automatic t_syscall;
        op(3'h1, 0, 0, 0, 0, 0);
        chk("sc_exc", SYSCALL_EXC, 1);
        chk("sc_prog", PROG_EXC, 0);
        chk("sc_done", RES_VALID, 1);
        chk("irq_masked", IRQ, 0);
        bus(1, 8'h08, 32'h1);
        @(posedge CLOCK);
        #1;
        chk("irq_on", IRQ, 1);
        bus(0, 8'h04, 0);
        chk("status_sc", rd, 32'h1);
        @(posedge CLOCK);
        #1;
        chk("irq_clr", IRQ, 0);
    endtask

    // Each mask bit alone against operand pairs with known outcomes.
    task automatic t_trap;
        logic [31:0] ta[3] = '{32'hffffffff, 32'h7, 32'h1};
        logic [31:0] tx[3] = '{32'h1, 32'h7, 32'h0};
        logic [4:0]  tv[3] = '{5'h11, 5'h04, 5'h0a};
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 5; i++) begin
                op(k == 2 ? 3'h3 : 3'h2, 5'h1 << i, ta[k], tx[k], 16'h8000, 1);
                chk("trap", PROG_EXC, tv[k][i]);
                chk("next", NEXT_SEQ, !tv[k][i]);
            end
        end
        op(3'h2, 5'h00, 32'h7, 32'h7, 0, 1);
        chk("mask_off", PROG_EXC, 0);
        op(3'h3, 5'h1f, 32'h5, 0, 16'h5, 1);
        chk("mask_all", PROG_EXC, 1);
        bus(0, 8'h0c, 0);
        chk("trapcnt", rd, 32'hb);
    endtask

    task automatic t_ea;
        upd = 1;
        op(3'h4, 0, 32'h1000, 0, 16'hfffc, 5'h3);
        chk("ea_valid", EA_VALID, 1);
        chk("ea_imm", EA, 32'h0ffc);
        chk("wb_en", WB_EN, 1);
        chk("wb_sel", WB_SEL, 5'h3);
        chk("wb_data", WB_DATA, 32'h0ffc);
        upd = 0;
        op(3'h4, 0, 32'h1000, 0, 16'hfffc, 5'h0);
        chk("ea_imm_zero", EA, 32'hfffffffc);
        chk("wb_off", WB_EN, 0);
        op(3'h5, 0, 32'h1000, 32'h20, 0, 5'h2);
        chk("ea_idx", EA, 32'h1020);
        op(3'h5, 0, 32'h1000, 32'h20, 0, 5'h0);
        chk("ea_idx_zero", EA, 32'h20);
        op(3'h6, 0, 32'h1000, 0, 0, 5'h4);
        chk("ind_no_str", MODE_ERR, 1);
        str = 1;
        op(3'h6, 0, 32'h1000, 0, 0, 5'h4);
        chk("ind_err", MODE_ERR, 0);
        chk("ind_ea", EA, 32'h1000);
        str = 0;
        bus(0, 8'h10, 0);
        chk("last_ea", rd, 32'h1000);
        chk("irq_unmasked_off", IRQ, 0);
        bus(0, 8'h04, 0);
        chk("status_trap_mode", rd, 32'h6);
    endtask

    task automatic t_sync;
        @(posedge CLOCK);
        MEM_PENDING <= 1'b1;
        op(3'h7, 0, 0, 0, 0, 0);
        chk("fence_busy", OP_READY, 0);
        repeat (3) @(posedge CLOCK);
        #1;
        chk("fence_wait", FENCE_DONE, 0);
        @(posedge CLOCK);
        MEM_PENDING <= 1'b0;
        @(posedge CLOCK);
        #1;
        chk("fence_done", FENCE_DONE, 1);
        op(3'h7, 0, 0, 0, 0, 0);
        chk("fence_quick", FENCE_DONE, 1);
    endtask

    initial begin
        {HSEL, HWRITE, OP_VALID, UPDATE_FORM, STRING_OP, MEM_PENDING} = '0;
        {HTRANS, HADDR, HWDATA, OP_CODE, TRAP_CONDITION_MASK} = '0;
        {BASE_REG_SEL, SIGNED_IMMEDIATE, BASE_VALUE, INDEX_VALUE} = '0;
        CLOCK = 1'b0;
        SYS_RST = 1'b1;
        USER_MODE = 1'b1;
        upd = 0;
        str = 0;
        repeat (12) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        t_regs;
        t_syscall;
        t_trap;
        t_ea;
        t_sync;
        final_report;
    end
endmodule
`default_nettype wire
